/* core/sfp_defines.vh */
// constants for the serial flash pin and hold front end
// assumes plain verilog includes by bare name
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH
`define SFP_ADDR_W 20
`define SFP_TOP_ADDR 20'hfffff
`define SFP_PAGE_SHIFT 8
`define SFP_BLK4_SHIFT 12
`define SFP_BLK32_SHIFT 15
`define SFP_SECT_SHIFT 16
`define SFP_ERASE_4K 3'h1
`define SFP_ERASE_32K 3'h2
`define SFP_ERASE_64K 3'h3
`define SFP_ERASE_CHIP 3'h4
`define SFP_ERASE_NONE 3'h0
`define SFP_MODE_SINGLE 2'h0
`define SFP_MODE_DUAL 2'h1
`define SFP_MODE_QUAD 2'h2
`define SFP_FIFO_DEPTH 16
`endif

/* core/sfp_fifo.v */
// small flip-flop fifo with valid/ready on both sides
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/1ps
module sfp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage
    reg [AW-1:0] wr_q; // write index
    reg [AW-1:0] rd_q; // read index
    reg [AW:0] cnt_q; // fill level
    wire push;
    wire pop;
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // storage write
    always @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    // pointers and level
    always @(posedge clk) begin
        if (reset) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

/* core/sfp_pin_io.v */
// serial flash pin front end: shifter, multi-line output, hold pause
// assumes a slower spi clock on pins, sampled by clk; the command
// decoder beside it picks the mode and feeds read bytes via the fifo
`timescale 1ns/1ps
`include "sfp_defines.vh"
module sfp_pin_io #(
    parameter DEPTH = `SFP_FIFO_DEPTH
) (
    input wire clk,
    input wire reset,
    input wire cs_n_pin,
    input wire sck_pin,
    input wire [3:0] quad_data_lines_i,
    output wire [3:0] quad_data_lines_o,
    output wire [3:0] quad_data_lines_oe_n,
    input wire [1:0] out_mode,
    input wire out_active,
    input wire [7:0] rd_data,
    input wire rd_valid,
    output wire rd_ready,
    output reg [7:0] rx_byte_q,
    output reg rx_valid_q,
    output reg frame_start_q,
    output reg frame_end_q,
    output reg selected_q,
    output reg hold_active_q,
    output reg wp_lock_q,
    input wire [`SFP_ADDR_W-1:0] erase_addr,
    input wire [2:0] erase_kind,
    output reg [`SFP_ADDR_W-1:0] erase_base_q,
    output reg [`SFP_ADDR_W-1:0] erase_last_q
);
    // two-stage synchronisers for clock and data pins, three stages for chip select
    reg [1:0] cs_s1_q;
    reg [1:0] cs_s2_q;
    reg sck_s1_q;
    reg sck_s2_q;
    reg sck_prev_q;
    reg [3:0] io_s1_q;
    reg [3:0] io_s2_q;
    always @(posedge clk) begin
        if (reset) begin
            cs_s1_q <= 2'h3;
            cs_s2_q <= 2'h3;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_prev_q <= 1'b0;
            io_s1_q <= 4'hf;
            io_s2_q <= 4'hf;
        end else begin
            cs_s1_q <= {cs_s1_q[0], cs_n_pin};
            cs_s2_q <= {cs_s2_q[0], cs_s1_q[1]};
            sck_s1_q <= sck_pin;
            sck_s2_q <= sck_s1_q;
            sck_prev_q <= sck_s2_q;
            io_s1_q <= quad_data_lines_i; // undriven pins arrive high (pull-up)
            io_s2_q <= io_s1_q;
        end
    end
    wire cs_n = cs_s2_q[0];
    wire cs_n_prev = cs_s2_q[1];
    wire sck_rise = sck_s2_q & ~sck_prev_q;
    wire sck_fall = ~sck_s2_q & sck_prev_q;
    // hold and protect pins are inputs only outside quad output
    wire quad_out = out_active & (out_mode == `SFP_MODE_QUAD);
    wire dual_out = out_active & (out_mode == `SFP_MODE_DUAL);
    wire hold_pin_n = quad_out ? 1'b1 : io_s2_q[3];
    wire wp_pin_n = quad_out ? 1'b1 : io_s2_q[2];
    wire hold_now = hold_active_q | (~hold_pin_n & ~sck_s2_q);
    wire live = ~cs_n & ~hold_now; // clock edges count only here

    // fifo between read data source and output shifter
    wire [7:0] ff_data;
    wire ff_valid;
    reg ff_pop;
    // an empty fifo sends a zero byte, never stale storage
    wire [7:0] ff_byte = ff_valid ? ff_data : 8'h00;
    sfp_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(4)) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_data(rd_data),
        .in_valid(rd_valid),
        .in_ready(rd_ready),
        .out_data(ff_data),
        .out_valid(ff_valid),
        .out_ready(ff_pop)
    );

    // frame, hold and protect tracking
    always @(posedge clk) begin
        if (reset) begin
            selected_q <= 1'b0;
            hold_active_q <= 1'b0;
            frame_start_q <= 1'b0;
            frame_end_q <= 1'b0;
            wp_lock_q <= 1'b0;
        end else begin
            frame_start_q <= cs_n_prev & ~cs_n; // falling select starts
            frame_end_q <= ~cs_n_prev & cs_n; // rising select ends
            selected_q <= ~cs_n;
            wp_lock_q <= ~wp_pin_n; // low protect pin locks blocks
            if (cs_n) begin
                hold_active_q <= 1'b0;
            end else if (~hold_pin_n & ~sck_s2_q) begin
                hold_active_q <= 1'b1; // pause, no state lost
            end else if (hold_pin_n) begin
                hold_active_q <= 1'b0; // resume in place
            end
        end
    end

    // input shifter and output shifter; state kept across hold
    reg [2:0] in_cnt_q; // bit position of receive byte
    reg [6:0] in_sh_q;
    reg [7:0] out_sh_q; // bits being sent, msb first
    reg [3:0] out_left_q; // bits left in out_sh_q
    reg [3:0] drive_q; // registered line values
    reg out_loaded_q;
    reg [2:0] step;
    always @* begin
        ff_pop = 1'b0;
        step = dual_out ? 3'h2 : (quad_out ? 3'h4 : 3'h1);
        if (live & sck_fall & out_active & (out_left_q == 4'h0) & ff_valid) begin
            ff_pop = 1'b1;
        end
    end
    always @(posedge clk) begin
        if (reset) begin
            in_cnt_q <= 3'h0;
            in_sh_q <= 7'h00;
            rx_byte_q <= 8'h00;
            rx_valid_q <= 1'b0;
            out_sh_q <= 8'h00;
            out_left_q <= 4'h0;
            drive_q <= 4'h0;
            out_loaded_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (cs_n) begin
                in_cnt_q <= 3'h0;
                out_left_q <= 4'h0;
                out_loaded_q <= 1'b0;
            end else if (live & sck_rise & ~out_active) begin
                // sample serial input on rising edge
                in_sh_q <= {in_sh_q[5:0], io_s2_q[0]};
                in_cnt_q <= in_cnt_q + 3'h1;
                if (in_cnt_q == 3'h7) begin
                    rx_byte_q <= {in_sh_q, io_s2_q[0]};
                    rx_valid_q <= 1'b1;
                end
            end else if (live & sck_fall & out_active) begin
                // change outputs on falling edge only
                out_loaded_q <= 1'b1;
                if (out_left_q == 4'h0) begin
                    if (quad_out) begin
                        drive_q <= ff_byte[7:4]; // four bits per edge
                        out_sh_q <= {ff_byte[3:0], 4'h0};
                    end else if (dual_out) begin
                        drive_q <= {2'h0, ff_byte[7:6]}; // two bits per edge
                        out_sh_q <= {ff_byte[5:0], 2'h0};
                    end else begin
                        drive_q <= {2'h0, ff_byte[7], 1'b0}; // single line out
                        out_sh_q <= {ff_byte[6:0], 1'b0};
                    end
                    out_left_q <= ff_valid ? (4'h8 - {1'b0, step}) : 4'h0;
                end else begin
                    if (quad_out) begin
                        drive_q <= out_sh_q[7:4];
                        out_sh_q <= {out_sh_q[3:0], 4'h0};
                    end else if (dual_out) begin
                        drive_q <= {2'h0, out_sh_q[7:6]};
                        out_sh_q <= {out_sh_q[5:0], 2'h0};
                    end else begin
                        drive_q <= {2'h0, out_sh_q[7], 1'b0};
                        out_sh_q <= {out_sh_q[6:0], 1'b0};
                    end
                    out_left_q <= out_left_q - {1'b0, step};
                end
            end
        end
    end

    // output enables, low while driving; float when deselected or held
    wire drv = out_active & out_loaded_q & ~cs_n & ~hold_active_q;
    assign quad_data_lines_o = drive_q;
    assign quad_data_lines_oe_n[1] = ~drv; // serial output line
    assign quad_data_lines_oe_n[0] = ~(drv & (dual_out | quad_out));
    assign quad_data_lines_oe_n[2] = ~(drv & quad_out);
    assign quad_data_lines_oe_n[3] = ~(drv & quad_out);

    // erase range decode: hold has no path here, so it never pauses it
    always @(posedge clk) begin
        if (reset) begin
            erase_base_q <= {`SFP_ADDR_W{1'b0}};
            erase_last_q <= {`SFP_ADDR_W{1'b0}};
        end else begin
            case (erase_kind)
                `SFP_ERASE_4K: begin
                    erase_base_q <= {erase_addr[19:`SFP_BLK4_SHIFT], 12'h000};
                    erase_last_q <= {erase_addr[19:`SFP_BLK4_SHIFT], 12'hfff};
                end
                `SFP_ERASE_32K: begin
                    erase_base_q <= {erase_addr[19:`SFP_BLK32_SHIFT], 15'h0000};
                    erase_last_q <= {erase_addr[19:`SFP_BLK32_SHIFT], 15'h7fff};
                end
                `SFP_ERASE_64K: begin
                    erase_base_q <= {erase_addr[19:`SFP_SECT_SHIFT], 16'h0000};
                    erase_last_q <= {erase_addr[19:`SFP_SECT_SHIFT], 16'hffff};
                end
                `SFP_ERASE_CHIP: begin
                    erase_base_q <= {`SFP_ADDR_W{1'b0}};
                    erase_last_q <= `SFP_TOP_ADDR;
                end
                default: begin
                    erase_base_q <= erase_base_q;
                    erase_last_q <= erase_last_q;
                end
            endcase
        end
    end
endmodule

/* testbench/sfp_pin_io_checker.sv */
// assertions on the pin front end ports
// assumes binding into sfp_pin_io, one clock, sync reset
`timescale 1ns/1ps
`include "sfp_defines.vh"
module sfp_pin_io_checker (
    input logic clk,
    input logic reset,
    input logic cs_n_pin,
    input logic sck_pin,
    input logic [3:0] quad_data_lines_i,
    input logic [3:0] quad_data_lines_o,
    input logic [3:0] quad_data_lines_oe_n,
    input logic [1:0] out_mode,
    input logic selected_q,
    input logic hold_active_q,
    input logic wp_lock_q,
    input logic [`SFP_ADDR_W-1:0] erase_addr,
    input logic [2:0] erase_kind,
    input logic [`SFP_ADDR_W-1:0] erase_base_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // pause lasting past its first edge
    sequence held_s;
        hold_active_q [*2];
    endsequence
    // protect pin steady while it is an input
    sequence wp_low_s;
        (!quad_data_lines_i[2] && out_mode != `SFP_MODE_QUAD) [*6];
    endsequence
    sequence wp_high_s;
        (quad_data_lines_i[2] && out_mode != `SFP_MODE_QUAD) [*6];
    endsequence
    float_desel_a: assert property (cs_n_pin [*5] |-> quad_data_lines_oe_n == 4'hf)
        else $error("driven while deselected");
    float_hold_a: assert property (held_s |-> quad_data_lines_oe_n == 4'hf)
        else $error("driven during hold");
    single_line_a: assert property (out_mode == `SFP_MODE_SINGLE |-> (quad_data_lines_oe_n | 4'h2) == 4'hf)
        else $error("extra line in single mode");
    dual_line_a: assert property (out_mode == `SFP_MODE_DUAL |-> (quad_data_lines_oe_n | 4'h3) == 4'hf)
        else $error("extra line in dual mode");
    out_fall_a: assert property ($rose(sck_pin) |=> $stable(quad_data_lines_o) [*2])
        else $error("output moved near rising edge");
    hold_sel_a: assert property ($rose(hold_active_q) |-> selected_q)
        else $error("hold while deselected");
    lock_low_a: assert property (wp_low_s |-> wp_lock_q)
        else $error("lock missing");
    lock_high_a: assert property (wp_high_s |-> !wp_lock_q)
        else $error("lock without low pin");
    erase_4k_a: assert property (erase_kind == `SFP_ERASE_4K |=> erase_base_q == {$past(erase_addr[19:12]), 12'h000})
        else $error("bad 4k base");
endmodule
bind sfp_pin_io sfp_pin_io_checker i_sfp_pin_io_checker (
    .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
    .quad_data_lines_i(quad_data_lines_i), .quad_data_lines_o(quad_data_lines_o),
    .quad_data_lines_oe_n(quad_data_lines_oe_n), .out_mode(out_mode),
    .selected_q(selected_q), .hold_active_q(hold_active_q), .wp_lock_q(wp_lock_q),
    .erase_addr(erase_addr), .erase_kind(erase_kind), .erase_base_q(erase_base_q)
);

/* testbench/sfp_host_model.sv */
// spi host model: frames, clocks and shifts the serial lines
// assumes the bench resolves the shared lines with pull-ups
`timescale 1ns/1ps
module sfp_host_model (
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic si_en,
    input logic [3:0] lines
);
    // idle: deselected, clock parked low, input released
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b1;
        si_en = 1'b0;
    end
    // chip select edges bracket every operation
    task automatic frame(input logic lvl);
        #30 cs_n = lvl;
        #30;
    endtask
    // n clock periods of w bits, data held over the rise
    task automatic xfer(input logic [7:0] tx, input int w, input int n, inout logic [7:0] rx);
        for (int i = 0; i < n; i++) begin
            si_en = (w == 1);
            si = tx[7-i];
            #24 sck = 1'b1;
            rx = w == 1 ? {rx[6:0], lines[1]} : w == 2 ? {rx[5:0], lines[1:0]} : {rx[3:0], lines};
            #24 sck = 1'b0;
        end
    endtask
endmodule

/* testbench/tb_top.sv */
// bench for the pin front end: host model, pulled lines, fifo feed
// assumes the host model and checker files are compiled first
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    wire cs_n_pin, sck_pin, si, si_en;
    logic wp_en = 1'b0, hd_en = 1'b0; // bench pulls protect or hold low
    wire [3:0] quad_data_lines_i, quad_data_lines_o, quad_data_lines_oe_n;
    logic [1:0] out_mode = 2'h0;
    logic out_active = 1'b0, rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00, last_rx;
    wire rd_ready, rx_valid_q, frame_start_q, frame_end_q, selected_q, hold_active_q, wp_lock_q;
    wire [7:0] rx_byte_q;
    logic [19:0] erase_addr = 20'h12345;
    logic [2:0] erase_kind = 3'h0;
    wire [19:0] erase_base_q, erase_last_q;
    int fails = 0, check_count = 0, n_rx = 0, n_fs = 0, n_fe = 0;
    wire [3:0] le = quad_data_lines_oe_n;
    always #2.5 clk = ~clk;
    // device where enabled, else host or bench, else pull-up
    assign quad_data_lines_i = ~le & quad_data_lines_o | le & {~hd_en, ~wp_en, 1'b1, si_en ? si : 1'b1};
    sfp_pin_io #(.DEPTH(16)) i_sfp_pin_io (
        .clk(clk), .reset(reset), .cs_n_pin(cs_n_pin), .sck_pin(sck_pin),
        .quad_data_lines_i(quad_data_lines_i), .quad_data_lines_o(quad_data_lines_o),
        .quad_data_lines_oe_n(quad_data_lines_oe_n), .out_mode(out_mode), .out_active(out_active),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rx_byte_q(rx_byte_q), .rx_valid_q(rx_valid_q),
        .frame_start_q(frame_start_q), .frame_end_q(frame_end_q),
        .selected_q(selected_q), .hold_active_q(hold_active_q), .wp_lock_q(wp_lock_q),
        .erase_addr(erase_addr), .erase_kind(erase_kind),
        .erase_base_q(erase_base_q), .erase_last_q(erase_last_q)
    );
    sfp_host_model i_sfp_host_model (.cs_n(cs_n_pin), .sck(sck_pin), .si(si), .si_en(si_en), .lines(quad_data_lines_i));
    // capture each received byte
    always @(posedge clk) begin
        if (rx_valid_q === 1'b1) begin
            last_rx <= rx_byte_q;
            n_rx <= n_rx + 1;
        end
        if (frame_start_q === 1'b1)
            n_fs <= n_fs + 1;
        if (frame_end_q === 1'b1)
            n_fe <= n_fe + 1;
    end
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_idle_wp;
        check(quad_data_lines_oe_n, 4'hf);
        check(wp_lock_q, 1'b0);
        wp_en = 1'b1;
        tick(8);
        check(wp_lock_q, 1'b1);
        wp_en = 1'b0;
        tick(8);
        check(wp_lock_q, 1'b0);
    endtask
    task automatic t_hold_rx;
        logic [7:0] rx;
        int n0;
        n0 = n_rx;
        i_sfp_host_model.frame(1'b0);
        i_sfp_host_model.xfer(8'hc3, 1, 4, rx);
        hd_en = 1'b1;
        tick(20);
        check(hold_active_q, 1'b1);
        i_sfp_host_model.xfer(8'hff, 1, 3, rx);
        check(quad_data_lines_oe_n, 4'hf);
        check(selected_q, 1'b1);
        hd_en = 1'b0;
        tick(20);
        i_sfp_host_model.xfer(8'h30, 1, 4, rx);
        tick(6);
        check(last_rx, 8'hc3);
        i_sfp_host_model.xfer(8'h96, 1, 8, rx);
        tick(6);
        check(last_rx, 8'h96);
        check(n_rx - n0, 2);
        i_sfp_host_model.frame(1'b1);
        tick(6);
        check(selected_q, 1'b0);
        check(n_fs, 1);
        check(n_fe, 1);
    endtask
    task automatic t_read;
        logic [7:0] rx;
        int n, idx;
        logic ok;
        n = 0;
        idx = 0;
        rd_data = 8'h10;
        rd_valid = 1'b1;
        repeat (20) begin
            ok = (rd_ready === 1'b1);
            @(posedge clk);
            if (ok)
                n++;
            #1 rd_data = 8'h10 + 8'(n);
        end
        rd_valid = 1'b0;
        check(n, 16);
        for (int m = 0; m < 3; m++) begin
            out_mode = 2'(m);
            out_active = 1'b1;
            i_sfp_host_model.frame(1'b0);
            i_sfp_host_model.xfer(8'h00, 8, 1, rx);
            for (int b = 0; b < (m == 2 ? 7 : 4); b++) begin
                i_sfp_host_model.xfer(8'hff, 1 << m, 8 >> m, rx);
                check(rx, idx < 16 ? 8'h10 + 8'(idx) : 8'h00);
                idx++;
            end
            i_sfp_host_model.frame(1'b1);
            tick(1);
            out_active = 1'b0;
            idx++;
        end
    endtask
    task automatic t_erase;
        logic [19:0] sz;
        for (int k = 1; k < 5; k++) begin
            sz = k == 1 ? 20'h01000 : k == 2 ? 20'h08000 : k == 3 ? 20'h10000 : 20'h00000;
            erase_kind = 3'(k);
            tick(1);
            erase_kind = 3'h0;
            tick(2);
            check(erase_base_q, erase_addr & ~(sz - 20'h1));
            check(erase_last_q, erase_addr & ~(sz - 20'h1) | (sz - 20'h1));
        end
    endtask
    // main sequence after three cycles of reset
    initial begin
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        tick(4);
        t_idle_wp;
        t_hold_rx;
        t_read;
        t_erase;
        end_sim;
    end
    // watchdog against a hang
    initial begin
        #60000;
        fails++;
        end_sim;
    end
endmodule
